/* common/aft_pkg.sv */
/*
  Shared constants and types of the output format and test pattern block:
  register offsets, field positions, reset values, test mode codes and
  the fixed pattern words.
  Assumes 8-bit registers at 13-bit offsets reached over a serial configuration port.
*/
package aft_pkg;

  // Register offsets
  localparam logic [12:0] ADDR_TEST_MODE      = 13'h000D;
  localparam logic [12:0] ADDR_OUT_FORMAT     = 13'h0014;
  localparam logic [12:0] ADDR_OUT_ADJUST     = 13'h0015;
  localparam logic [12:0] ADDR_REF_SELECT     = 13'h0018;
  localparam logic [12:0] ADDR_PAT1_LOW       = 13'h0019;
  localparam logic [12:0] ADDR_PAT1_HIGH      = 13'h001A;
  localparam logic [12:0] ADDR_PAT2_LOW       = 13'h001B;
  localparam logic [12:0] ADDR_PAT2_HIGH      = 13'h001C;
  localparam logic [12:0] ADDR_FILTER_TUNE    = 13'h002B;
  localparam logic [12:0] ADDR_IN_IMPEDANCE   = 13'h002C;

  // Reset values
  localparam logic [7:0]  RST_TEST_MODE       = 8'h00;
  localparam logic [7:0]  RST_OUT_FORMAT      = 8'h00;
  localparam logic [7:0]  RST_OUT_ADJUST      = 8'h0F;
  localparam logic [7:0]  RST_REF_SELECT      = 8'h03;
  localparam logic [7:0]  RST_PATTERN         = 8'h00;
  localparam logic [7:0]  RST_FILTER_TUNE     = 8'h00;
  localparam logic [7:0]  RST_IN_IMPEDANCE    = 8'h00;

  // Field positions
  localparam int          BIT_TWOS_COMP       = 0;
  localparam int          BIT_INVERT          = 2;
  localparam int          BIT_DATA_DISABLE    = 7;
  localparam int          BIT_REF_EXTERNAL    = 6;
  localparam int          BIT_AUTO_TUNE       = 6;
  localparam int          BIT_IMP_HIGH        = 0;

  // Test mode codes
  localparam logic [3:0]  MODE_OFF            = 4'h0;
  localparam logic [3:0]  MODE_MIDSCALE       = 4'h1;
  localparam logic [3:0]  MODE_POS_FULL       = 4'h2;
  localparam logic [3:0]  MODE_NEG_FULL       = 4'h3;
  localparam logic [3:0]  MODE_CHECKER        = 4'h4;
  localparam logic [3:0]  MODE_PN_LONG        = 4'h5;
  localparam logic [3:0]  MODE_PN_SHORT       = 4'h6;
  localparam logic [3:0]  MODE_WORD_TOGGLE    = 4'h7;
  localparam logic [3:0]  MODE_USER           = 4'h8;
  localparam logic [3:0]  MODE_BIT_TOGGLE     = 4'h9;
  localparam logic [3:0]  MODE_SYNC           = 4'hA;
  localparam logic [3:0]  MODE_ONE_BIT_HIGH   = 4'hB;
  localparam logic [3:0]  MODE_MIXED_FREQ     = 4'hC;

  // Fixed pattern words
  localparam logic [11:0] WORD_MIDSCALE       = 12'h800;
  localparam logic [11:0] WORD_ONES           = 12'hFFF;
  localparam logic [11:0] WORD_ZEROS          = 12'h000;
  localparam logic [11:0] WORD_CHECKER_A      = 12'hAAA;
  localparam logic [11:0] WORD_CHECKER_B      = 12'h555;
  localparam logic [11:0] WORD_SYNC           = 12'h03F;
  localparam logic [11:0] WORD_MIXED_FREQ     = 12'hA33;

  // Pseudo-noise generator seed
  localparam logic [22:0] PN_SEED             = 23'h7FFFFF;

  // Serial frame lengths in rising edges of the serial clock
  localparam logic [4:0]  SPI_INSTR_BITS      = 5'd16;
  localparam logic [4:0]  SPI_FRAME_BITS      = 5'd24;

  // Serial port states
  typedef enum logic [3:0] {
    AFT_SPI_IDLE  = 4'b0001,
    AFT_SPI_INSTR = 4'b0010,
    AFT_SPI_DATA  = 4'b0100,
    AFT_SPI_DONE  = 4'b1000
  } aft_spi_state_e;

  // Decoded instruction
  typedef struct packed {
    logic        rd;
    logic [12:0] addr;
  } aft_cmd_s;

endpackage : aft_pkg

/* verilog/aft_top.sv */
/*
  Output format and test pattern block with its configuration registers.
  Assumes serial port pins and conversion data are synchronous to i_ref_clk
  and that each rising clock edge carries one conversion sample.
*/
`timescale 1ns/1ps

module aft_top (
  input  wire logic        i_ref_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_spi_sclk,
  input  wire logic        i_spi_csb_n,
  input  wire logic        i_spi_sdi,
  output logic             o_spi_sdo,
  output logic             o_spi_sdo_oe_n,
  input  wire logic [11:0] i_conv_data,
  output logic      [11:0] o_data,
  output logic             o_data_oe_n,
  output logic             o_ref_external,
  output logic      [1:0]  o_ref_level,
  output logic      [3:0]  o_drive_cfg,
  output logic             o_tune_start,
  output logic             o_imp_high
);
  import aft_pkg::*;

  // Configuration registers
  logic [3:0]     mode_r;
  logic [7:0]     fmt_r;
  logic [7:0]     adj_r;
  logic [7:0]     ref_r;
  logic [15:0]    pat1_r;
  logic [15:0]    pat2_r;
  logic           tune_r;
  logic           imp_r;

  // Serial port state
  aft_spi_state_e spi_st_r;
  logic           sclk_q_r;
  logic [4:0]     bit_cnt_r;
  logic [15:0]    rx_r;
  logic [7:0]     tx_r;
  aft_cmd_s       cmd_r;
  logic           sdo_r;
  logic           sdo_oe_n_r;

  // Pattern generator state
  logic [3:0]     mode_q_r;
  logic           word_sel_r;
  logic [22:0]    pn_r;
  logic [11:0]    data_r;
  logic           data_oe_n_r;

  // Serial clock edges and frame events
  // The serial clock is oversampled here, so each level must last at least one sample
  wire            sclk_rise  = i_spi_sclk & ~sclk_q_r;
  wire            sclk_fall  = ~i_spi_sclk & sclk_q_r;
  wire            instr_done = sclk_rise && (bit_cnt_r == SPI_INSTR_BITS - 5'd1);
  wire            frame_done = sclk_rise && (bit_cnt_r == SPI_FRAME_BITS - 5'd1);
  wire [7:0]      wr_data    = {rx_r[6:0], i_spi_sdi};
  wire            wr_en      = !i_spi_csb_n && (spi_st_r == AFT_SPI_DATA)
                               && frame_done && !cmd_r.rd;
  wire aft_cmd_s  cmd_nxt    = '{rd: rx_r[14], addr: {rx_r[11:0], i_spi_sdi}};

  // Address hit for a read or a write
  function automatic logic hit(input logic [12:0] a, input logic [12:0] target);
    hit = (a == target);
  endfunction : hit

  // Register read mux
  logic [7:0] rd_data;
  always_comb begin
    if (hit(cmd_nxt.addr, ADDR_TEST_MODE))         rd_data = {4'h0, mode_r};
    else if (hit(cmd_nxt.addr, ADDR_OUT_FORMAT))   rd_data = fmt_r;
    else if (hit(cmd_nxt.addr, ADDR_OUT_ADJUST))   rd_data = adj_r;
    else if (hit(cmd_nxt.addr, ADDR_REF_SELECT))   rd_data = ref_r;
    else if (hit(cmd_nxt.addr, ADDR_PAT1_LOW))     rd_data = pat1_r[7:0];
    else if (hit(cmd_nxt.addr, ADDR_PAT1_HIGH))    rd_data = pat1_r[15:8];
    else if (hit(cmd_nxt.addr, ADDR_PAT2_LOW))     rd_data = pat2_r[7:0];
    else if (hit(cmd_nxt.addr, ADDR_PAT2_HIGH))    rd_data = pat2_r[15:8];
    else if (hit(cmd_nxt.addr, ADDR_FILTER_TUNE))  rd_data = {1'b0, tune_r, 6'h00};
    else if (hit(cmd_nxt.addr, ADDR_IN_IMPEDANCE)) rd_data = {7'h00, imp_r};
    else                                           rd_data = 8'h00;
  end

  // Serial state machine
  aft_spi_state_e spi_st_nxt;
  always_comb begin
    spi_st_nxt = spi_st_r;
    case (spi_st_r)
      AFT_SPI_IDLE:  spi_st_nxt = AFT_SPI_INSTR;
      AFT_SPI_INSTR: if (instr_done) spi_st_nxt = AFT_SPI_DATA;
      AFT_SPI_DATA:  if (frame_done) spi_st_nxt = AFT_SPI_DONE;
      AFT_SPI_DONE:  spi_st_nxt = AFT_SPI_DONE;
      default:       spi_st_nxt = AFT_SPI_IDLE;
    endcase
    if (i_spi_csb_n) spi_st_nxt = AFT_SPI_IDLE;
  end

  // Serial shift, count and read-out
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      spi_st_r   <= AFT_SPI_IDLE;
      sclk_q_r   <= 1'b0;
      bit_cnt_r  <= 5'd0;
      rx_r       <= 16'h0000;
      tx_r       <= 8'h00;
      cmd_r      <= '0;
      sdo_r      <= 1'b0;
      sdo_oe_n_r <= 1'b1;
    end else begin
      spi_st_r <= spi_st_nxt;
      sclk_q_r <= i_spi_sclk;
      if (i_spi_csb_n) begin
        bit_cnt_r  <= 5'd0;
        sdo_oe_n_r <= 1'b1;
      end else if (sclk_rise && spi_st_r != AFT_SPI_DONE) begin
        bit_cnt_r <= bit_cnt_r + 5'd1;
        rx_r      <= {rx_r[14:0], i_spi_sdi};
        if (instr_done) begin
          cmd_r <= cmd_nxt;
          tx_r  <= rd_data;
        end
      end else if (sclk_fall && spi_st_r == AFT_SPI_DATA && cmd_r.rd) begin
        sdo_r      <= tx_r[7];
        sdo_oe_n_r <= 1'b0;
        tx_r       <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // Register writes
  // Unmapped offsets miss every compare, so such writes are dropped
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_r <= RST_TEST_MODE[3:0];
      fmt_r  <= RST_OUT_FORMAT;
      adj_r  <= RST_OUT_ADJUST;
      ref_r  <= RST_REF_SELECT;
      pat1_r <= {RST_PATTERN, RST_PATTERN};
      pat2_r <= {RST_PATTERN, RST_PATTERN};
      imp_r  <= RST_IN_IMPEDANCE[BIT_IMP_HIGH];
    end else if (wr_en) begin
      if (hit(cmd_r.addr, ADDR_TEST_MODE))    mode_r <= wr_data[3:0];
      if (hit(cmd_r.addr, ADDR_OUT_FORMAT))   fmt_r <= wr_data;
      if (hit(cmd_r.addr, ADDR_OUT_ADJUST))   adj_r <= wr_data;
      if (hit(cmd_r.addr, ADDR_REF_SELECT))   ref_r <= wr_data;
      if (hit(cmd_r.addr, ADDR_PAT1_LOW))     pat1_r[7:0] <= wr_data;
      if (hit(cmd_r.addr, ADDR_PAT1_HIGH))    pat1_r[15:8] <= wr_data;
      if (hit(cmd_r.addr, ADDR_PAT2_LOW))     pat2_r[7:0] <= wr_data;
      if (hit(cmd_r.addr, ADDR_PAT2_HIGH))    pat2_r[15:8] <= wr_data;
      if (hit(cmd_r.addr, ADDR_IN_IMPEDANCE)) imp_r <= wr_data[BIT_IMP_HIGH];
    end
  end

  // Auto-tune bit: one-cycle start pulse, then self-clears
  // A read after the pulse sees zero, as the bit has already cleared
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tune_r <= RST_FILTER_TUNE[BIT_AUTO_TUNE];
    end else begin
      tune_r <= wr_en && hit(cmd_r.addr, ADDR_FILTER_TUNE) && wr_data[BIT_AUTO_TUNE];
    end
  end

  // Twelve pseudo-noise bits per sample, long or short polynomial
  // Seed is restored outside noise modes, so every run starts alike
  function automatic logic [34:0] pn_adv(input logic [22:0] s, input logic short_seq);
    logic [22:0] st;
    logic [11:0] w;
    logic        fb;
    st = s;
    w  = 12'h000;
    for (int i = 0; i < 12; i++) begin
      fb = short_seq ? (st[8] ^ st[4]) : (st[22] ^ st[17]);
      w  = {w[10:0], fb};
      st = {st[21:0], fb};
      if (short_seq) st[22:9] = 14'h0000;
    end
    pn_adv = {w, st};
  endfunction : pn_adv

  // Pattern selection
  wire            is_pn     = (mode_r == MODE_PN_LONG) || (mode_r == MODE_PN_SHORT);
  wire [34:0]     pn_step   = pn_adv(pn_r, mode_r == MODE_PN_SHORT);
  wire            mode_chg  = (mode_r != mode_q_r);
  // Word one must lead in the first cycle of a new mode, ahead of the register
  wire            pair_sel  = mode_chg ? 1'b0 : word_sel_r;
  logic [11:0]    raw_word;
  logic           use_fmt;
  always_comb begin
    use_fmt  = 1'b0;
    raw_word = i_conv_data;
    case (mode_r)
      MODE_MIDSCALE:     begin raw_word = WORD_MIDSCALE; use_fmt = 1'b1; end
      MODE_POS_FULL:     begin raw_word = WORD_ONES;     use_fmt = 1'b1; end
      MODE_NEG_FULL:     begin raw_word = WORD_ZEROS;    use_fmt = 1'b1; end
      MODE_CHECKER:      raw_word = pair_sel ? WORD_CHECKER_B : WORD_CHECKER_A;
      MODE_PN_LONG,
      MODE_PN_SHORT:     begin raw_word = pn_step[34:23]; use_fmt = 1'b1; end
      MODE_WORD_TOGGLE:  raw_word = pair_sel ? WORD_ZEROS : WORD_ONES;
      MODE_USER:         raw_word = pair_sel ? pat2_r[15:4] : pat1_r[15:4];
      MODE_BIT_TOGGLE:   raw_word = WORD_CHECKER_A;
      MODE_SYNC:         raw_word = WORD_SYNC;
      MODE_ONE_BIT_HIGH: raw_word = WORD_MIDSCALE;
      MODE_MIXED_FREQ:   raw_word = WORD_MIXED_FREQ;
      default:           begin raw_word = i_conv_data; use_fmt = 1'b1; end
    endcase
  end

  // Format and inversion
  // Invert sits after format, so it also reaches the fixed patterns
  wire            twos      = fmt_r[BIT_TWOS_COMP];
  wire [11:0]     fmt_word  = (use_fmt && twos) ? {~raw_word[11], raw_word[10:0]} : raw_word;
  wire [11:0]     data_nxt  = fmt_r[BIT_INVERT] ? ~fmt_word : fmt_word;

  // Output word, word select and noise state
  // Bus enable lags the disable bit by one sample, like the data word
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q_r    <= MODE_OFF;
      word_sel_r  <= 1'b0;
      pn_r        <= PN_SEED;
      data_r      <= 12'h000;
      data_oe_n_r <= 1'b1;
    end else begin
      mode_q_r    <= mode_r;
      word_sel_r  <= ~pair_sel;
      pn_r        <= is_pn ? pn_step[22:0] : PN_SEED;
      data_r      <= data_nxt;
      data_oe_n_r <= adj_r[BIT_DATA_DISABLE];
    end
  end

  // Outputs
  assign o_spi_sdo      = sdo_r;
  assign o_spi_sdo_oe_n = sdo_oe_n_r;
  assign o_data         = data_r;
  assign o_data_oe_n    = data_oe_n_r;
  assign o_ref_external = ref_r[BIT_REF_EXTERNAL];
  assign o_ref_level    = ref_r[1:0];
  assign o_drive_cfg    = adj_r[3:0];
  assign o_tune_start   = tune_r;
  assign o_imp_high     = imp_r;

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  a_fmt_twos_flip: assert property (mode_r == MODE_OFF && twos && !fmt_r[BIT_INVERT]
    |=> o_data == {~$past(i_conv_data[11]), $past(i_conv_data[10:0])})
    else $error("two's complement does not flip top bit");
  a_fmt_invert: assert property (mode_r == MODE_SYNC && fmt_r[BIT_INVERT]
    |=> o_data == ~WORD_SYNC) else $error("output invert not applied");
  a_bus_disable: assert property (adj_r[BIT_DATA_DISABLE] |=> o_data_oe_n)
    else $error("data bus not disabled");
  a_ref_write: assert property (wr_en && hit(cmd_r.addr, ADDR_REF_SELECT)
    |=> o_ref_external == $past(wr_data[BIT_REF_EXTERNAL]) && o_ref_level == $past(wr_data[1:0]))
    else $error("reference write lost");
  a_pat_bytes: assert property (wr_en && hit(cmd_r.addr, ADDR_PAT1_HIGH)
    |=> pat1_r[15:8] == $past(wr_data) && $stable(pat1_r[7:0]))
    else $error("pattern high byte write wrong");
  a_user_pair: assert property ((mode_r == MODE_USER && !pair_sel && !fmt_r[BIT_INVERT])
    ##1 (mode_r == MODE_USER && !fmt_r[BIT_INVERT])
    |-> o_data == $past(pat1_r[15:4]) ##1 o_data == $past(pat2_r[15:4]))
    else $error("user pattern words out of order");
  a_tune_clear: assert property (tune_r |=> !tune_r)
    else $error("auto-tune bit not self-clearing");
  a_midscale: assert property (mode_r == MODE_MIDSCALE && !twos && !fmt_r[BIT_INVERT]
    |=> o_data == WORD_MIDSCALE) else $error("midscale word wrong");
  a_checker_alt: assert property ((mode_r == MODE_CHECKER && !fmt_r[BIT_INVERT])[*3]
    |-> (o_data == WORD_CHECKER_A || o_data == WORD_CHECKER_B) && o_data != $past(o_data))
    else $error("checkerboard does not alternate");
  a_pn_alive: assert property (is_pn |-> pn_r != 23'h000000)
    else $error("noise generator stuck at zero");
  a_word_toggle: assert property ((mode_r == MODE_WORD_TOGGLE && twos
    && !fmt_r[BIT_INVERT])[*3] |-> o_data == ~$past(o_data)) else $error("word toggle wrong");
  a_sync_word: assert property (mode_r == MODE_SYNC && twos && !fmt_r[BIT_INVERT]
    |=> o_data == WORD_SYNC) else $error("sync word follows format");
  a_one_bit: assert property (mode_r == MODE_ONE_BIT_HIGH && twos && !fmt_r[BIT_INVERT]
    |=> o_data == WORD_MIDSCALE) else $error("one bit high word follows format");
  a_conv_pass: assert property (mode_r == MODE_OFF && !twos && !fmt_r[BIT_INVERT]
    |=> o_data == $past(i_conv_data)) else $error("conversion data not passed");
  a_pair_restart: assert property (mode_chg && mode_r == MODE_CHECKER
    && !fmt_r[BIT_INVERT] |=> o_data == WORD_CHECKER_A)
    else $error("two-word pattern not restarted");

  // Format handling of the remaining fixed words
  a_pos_full: assert property (mode_r == MODE_POS_FULL && twos && !fmt_r[BIT_INVERT]
    |=> o_data == {~WORD_ONES[11], WORD_ONES[10:0]})
    else $error("plus full scale ignores format");
  a_neg_full: assert property (mode_r == MODE_NEG_FULL && !twos && !fmt_r[BIT_INVERT]
    |=> o_data == WORD_ZEROS)
    else $error("minus full scale word wrong");
  a_bit_toggle: assert property (mode_r == MODE_BIT_TOGGLE && twos
    && !fmt_r[BIT_INVERT] |=> o_data == WORD_CHECKER_A)
    else $error("bit toggle word follows format");
  a_mixed_word: assert property (mode_r == MODE_MIXED_FREQ && twos
    && !fmt_r[BIT_INVERT] |=> o_data == WORD_MIXED_FREQ)
    else $error("mixed frequency word follows format");

  // Register writes land where the outputs expect them, and the bus and serial output enables follow
  a_fmt_write: assert property (wr_en && hit(cmd_r.addr, ADDR_OUT_FORMAT)
    |=> fmt_r == $past(wr_data))
    else $error("format register write lost");
  a_drive_write: assert property (wr_en && hit(cmd_r.addr, ADDR_OUT_ADJUST)
    |=> o_drive_cfg == $past(wr_data[3:0])
    && adj_r[BIT_DATA_DISABLE] == $past(wr_data[BIT_DATA_DISABLE]))
    else $error("output adjust write lost");
  a_bus_enable: assert property (!adj_r[BIT_DATA_DISABLE] |=> !o_data_oe_n)
    else $error("data bus not enabled");
  a_pat1_low: assert property (wr_en && hit(cmd_r.addr, ADDR_PAT1_LOW)
    |=> pat1_r[7:0] == $past(wr_data) && $stable(pat1_r[15:8]))
    else $error("pattern low byte write wrong");
  a_pat2_low: assert property (wr_en && hit(cmd_r.addr, ADDR_PAT2_LOW)
    |=> pat2_r[7:0] == $past(wr_data) && $stable(pat2_r[15:8]))
    else $error("second pattern low byte write wrong");
  a_tune_pulse: assert property (wr_en && hit(cmd_r.addr, ADDR_FILTER_TUNE)
    && wr_data[BIT_AUTO_TUNE] |=> o_tune_start)
    else $error("auto-tune start pulse missing");
  a_sdo_release: assert property (i_spi_csb_n |=> o_spi_sdo_oe_n)
    else $error("serial output still driven after deselect");

  // Main scenarios reached
  c_reg_write: cover property (wr_en);
  c_reg_read:  cover property (!o_spi_sdo_oe_n);
  c_user_mode: cover property ((mode_r == MODE_USER) [*4]);
  c_tune:      cover property (o_tune_start);
  c_pair_new:  cover property (mode_chg && mode_r == MODE_CHECKER);

endmodule : aft_top

/* sim/aft_rx_model.sv */
/*
  Capturing logic at the far side of the parallel conversion data bus.
  Assumes words are launched on the rising edge and are stable by the
  falling edge of the same sample clock.
*/
`timescale 1ns/1ps
module aft_rx_model (
  input  wire logic        i_clk,
  input  wire logic [11:0] i_data,
  input  wire logic        i_oe_n,
  output logic      [11:0] o_cur,
  output logic      [11:0] o_prev
);
  // Mid-eye capture of the last two words; a released bus reads inverted
  always @(negedge i_clk) begin
    o_prev <= o_cur;
    o_cur  <= i_oe_n ? ~o_cur : i_data;
  end
endmodule : aft_rx_model

/* sim/tb.sv */
/*
  Self-checking bench for the output format and test pattern block.
  Assumes aft_pkg and aft_rx_model are compiled before this file.
*/
`timescale 1ns/1ps
module tb;
  import aft_pkg::*;
  localparam int LIMIT = 20000;
  logic        i_ref_clk = 1'b0;
  logic        i_arst_n  = 1'b0;
  logic        sclk      = 1'b0;
  logic        csb_n     = 1'b1;
  logic        sdi       = 1'b0;
  logic [11:0] conv      = 12'h123;
  logic [11:0] o_data, cur, prev;
  logic        sdo, sdo_oe_n, oe_n, ref_ext, tune, imp;
  logic [1:0]  ref_lvl;
  logic [3:0]  drive;
  logic [7:0]  rb;
  logic [11:0] q [4];
  int          error_cnt   = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  int          tune_cnt    = 0;
  logic [12:0] ra [11] = '{ADDR_TEST_MODE, ADDR_OUT_FORMAT, ADDR_OUT_ADJUST, ADDR_REF_SELECT,
    ADDR_PAT1_LOW, ADDR_PAT1_HIGH, ADDR_PAT2_LOW, ADDR_PAT2_HIGH, ADDR_FILTER_TUNE,
    ADDR_IN_IMPEDANCE, 13'h0020};
  logic [7:0]  rv [11] = '{RST_TEST_MODE, RST_OUT_FORMAT, RST_OUT_ADJUST, RST_REF_SELECT,
    RST_PATTERN, RST_PATTERN, RST_PATTERN, RST_PATTERN, RST_FILTER_TUNE, RST_IN_IMPEDANCE, 8'h00};
  logic [3:0]  fc [7] = '{MODE_MIDSCALE, MODE_POS_FULL, MODE_NEG_FULL, MODE_BIT_TOGGLE,
    MODE_SYNC, MODE_ONE_BIT_HIGH, MODE_MIXED_FREQ};
  logic [11:0] fw [7] = '{WORD_MIDSCALE, WORD_ONES, WORD_ZEROS, WORD_CHECKER_A, WORD_SYNC,
    12'h800, WORD_MIXED_FREQ};
  logic [0:6]  fs = 7'b1110000;
  logic [3:0]  pc [3] = '{MODE_CHECKER, MODE_WORD_TOGGLE, MODE_USER};
  logic [11:0] pa [3] = '{WORD_CHECKER_A, WORD_ONES, 12'hABC};
  logic [11:0] pb [3] = '{WORD_CHECKER_B, WORD_ZEROS, 12'h123};

  // Sample clock
  always #4 i_ref_clk = ~i_ref_clk;

  aft_top i_aft_top (
    .i_ref_clk      (i_ref_clk),
    .i_arst_n       (i_arst_n),
    .i_spi_sclk     (sclk),
    .i_spi_csb_n    (csb_n),
    .i_spi_sdi      (sdi),
    .o_spi_sdo      (sdo),
    .o_spi_sdo_oe_n (sdo_oe_n),
    .i_conv_data    (conv),
    .o_data         (o_data),
    .o_data_oe_n    (oe_n),
    .o_ref_external (ref_ext),
    .o_ref_level    (ref_lvl),
    .o_drive_cfg    (drive),
    .o_tune_start   (tune),
    .o_imp_high     (imp)
  );

  aft_rx_model i_aft_rx_model (
    .i_clk  (i_ref_clk),
    .i_data (o_data),
    .i_oe_n (oe_n),
    .o_cur  (cur),
    .o_prev (prev)
  );

  // Cycle ceiling and tune pulse counting
  always @(posedge i_ref_clk) begin
    cyc++;
    if (tune) tune_cnt++;
    if (cyc == LIMIT) begin
      error_cnt++;
      complete_run;
    end
  end

  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // One serial frame: two ref cycles per sclk level, read bits just before each rise
  task automatic spi(input logic r, input logic [12:0] a, input logic [7:0] d,
                     output logic [7:0] rdat);
    logic [23:0] f;
    f    = {r, 2'b00, a, d};
    rdat = 8'h00;
    @(negedge i_ref_clk);
    csb_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(negedge i_ref_clk);
      sclk = 1'b0;
      sdi  = f[i];
      repeat (2) @(negedge i_ref_clk);
      if (i < 8) rdat[i] = sdo;
      if (r && i < 8) chk("sdo_oe", 12'h000, {11'h0, sdo_oe_n});
      sclk = 1'b1;
      @(negedge i_ref_clk);
    end
    @(negedge i_ref_clk);
    csb_n = 1'b1;
    sclk  = 1'b0;
    repeat (2) @(negedge i_ref_clk);
  endtask : spi

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] x;
    spi(1'b0, a, d, x);
  endtask : wr

  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    spi(1'b1, a, 8'h00, d);
  endtask : rd

  task automatic smp;
    @(posedge i_ref_clk);
    #1;
  endtask : smp

  task automatic t_reset;
    for (int k = 0; k < 11; k++) begin
      rd(ra[k], rb);
      chk("reg", {4'h0, rv[k]}, {4'h0, rb});
    end
    chk("ref", 12'h003, {9'h0, ref_ext, ref_lvl});
    chk("drv", 12'h00F, {7'h0, oe_n, drive});
    chk("tune_imp", 12'h000, {10'h0, tune, imp});
  endtask : t_reset

  task automatic t_regs;
    wr(ADDR_REF_SELECT, 8'h42);
    rd(ADDR_REF_SELECT, rb);
    chk("ref", 12'h142, {3'h0, ref_ext, rb});
    chk("lvl", 12'h002, {10'h0, ref_lvl});
    wr(ADDR_IN_IMPEDANCE, 8'h01);
    chk("imp", 12'h001, {11'h0, imp});
    wr(ADDR_OUT_ADJUST, 8'h85);
    smp;
    chk("dis", 12'h015, {7'h0, oe_n, drive});
    chk("float", ~prev, cur);
    wr(ADDR_OUT_ADJUST, 8'h0F);
    smp;
    chk("en", 12'h00F, {7'h0, oe_n, drive});
    wr(13'h0020, 8'h55);
    rd(13'h0020, rb);
    chk("unmapped", 12'h000, {4'h0, rb});
    wr(ADDR_PAT1_LOW, 8'hCD);
    wr(ADDR_PAT1_HIGH, 8'hAB);
    wr(ADDR_PAT2_LOW, 8'h34);
    wr(ADDR_PAT2_HIGH, 8'h12);
    rd(ADDR_PAT1_HIGH, rb);
    chk("pat", 12'h0AB, {4'h0, rb});
  endtask : t_regs

  task automatic t_conv;
    smp;
    chk("conv", 12'h123, cur);
    wr(ADDR_OUT_FORMAT, 8'h01);
    smp;
    chk("twos", 12'h923, cur);
    wr(ADDR_OUT_FORMAT, 8'h05);
    smp;
    chk("inv", 12'h6DC, cur);
    wr(ADDR_TEST_MODE, {4'h0, MODE_SYNC});
    smp;
    chk("sync_inv", 12'hFC0, cur);
    wr(ADDR_OUT_FORMAT, 8'h00);
    wr(ADDR_TEST_MODE, 8'h0D);
    smp;
    chk("undef", 12'h123, cur);
  endtask : t_conv

  task automatic t_fixed;
    for (int f = 0; f < 2; f++) begin
      wr(ADDR_OUT_FORMAT, 8'(f));
      for (int k = 0; k < 7; k++) begin
        wr(ADDR_TEST_MODE, {4'h0, fc[k]});
        smp;
        chk("fixed", fw[k] ^ {fs[k] & f[0], 11'h0}, cur);
      end
    end
  endtask : t_fixed

  task automatic t_pair;
    wr(ADDR_OUT_FORMAT, 8'h01);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_TEST_MODE, {4'h0, pc[k]});
      smp;
      chk("first", pa[k], cur);
      repeat (3) begin
        chk("pair", (prev === pa[k]) ? pb[k] : pa[k], cur);
        smp;
      end
    end
  endtask : t_pair

  task automatic t_pn;
    for (int k = 0; k < 2; k++) begin
      for (int f = 0; f < 2; f++) begin
        wr(ADDR_TEST_MODE, 8'h00);
        wr(ADDR_OUT_FORMAT, 8'(f));
        wr(ADDR_TEST_MODE, (k == 0) ? {4'h0, MODE_PN_LONG} : {4'h0, MODE_PN_SHORT});
        for (int j = 0; j < 4; j++) begin
          smp;
          if (f == 0) q[j] = cur;
          else chk("pn", q[j] ^ 12'h800, cur);
        end
      end
      chk("pn_run", 12'h001, {11'h0, q[0] !== q[3]});
    end
  endtask : t_pn

  task automatic t_tune;
    tune_cnt = 0;
    wr(ADDR_FILTER_TUNE, 8'h40);
    smp;
    chk("tune", 12'h001, 12'(tune_cnt));
    rd(ADDR_FILTER_TUNE, rb);
    chk("tune_clr", 12'h000, {4'h0, rb});
    wr(ADDR_FILTER_TUNE, 8'h00);
    chk("tune_idle", 12'h001, 12'(tune_cnt));
  endtask : t_tune

  // Reset, then the scenarios in turn
  initial begin
    repeat (20) @(negedge i_ref_clk);
    i_arst_n = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    t_reset;
    t_regs;
    t_conv;
    t_fixed;
    t_pair;
    t_pn;
    t_tune;
    complete_run;
  end
endmodule : tb
